// *** logic/asj_exec.sv ***
// Execution of decimal adjust, decrement, skip, jump and increment.
`timescale 1ns/1ns
`include "asj_defs.svh"
// Behaviour
// - Decimal adjust working register, flags untouched.
// - Decrement addressed register, update zero flag.
// - Destination bit selects working or data register.
// - Decrement and skip leaves flags untouched.
// - Zero result discards fetched next instruction.
// - Skip takes one or two cycles.
// - Jump loads ten-bit target into counter.
// - Jump takes two cycles, prefetch discarded.
// - Increment addressed register, update zero flag.
module asj_exec
  import asj_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // Instruction issue
  input  wire logic       instr_valid_i,
  input  asj_instr_t      instr_i,
  // Register file read
  input  wire logic [7:0] rf_rdata_i,
  output logic [5:0]      rf_raddr_o,
  // Register file write
  output asj_rf_wr_t      rf_wr_o,
  // Core state
  input  wire logic [9:0] pc_i,
  input  wire logic       zero_i,
  output logic [7:0]      work_o,
  output logic            zero_o,
  output logic [9:0]      pc_o,
  output logic            pc_load_o,
  output logic            discard_o,
  output logic            busy_o
);
  logic       rst_s1_reg;
  logic       rst_s2_reg;
  logic       rst_n;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  asj_state_t  state_reg;
  asj_state_t  state_next;
  logic [7:0]  work_reg;
  logic [7:0]  work_next;
  logic        zero_reg;
  logic        zero_next;
  logic [9:0]  pc_reg;
  logic [9:0]  pc_next;
  logic        pc_load_reg;
  logic        pc_load_next;
  logic        discard_reg;
  logic        discard_next;
  asj_rf_wr_t  wr_reg;
  asj_rf_wr_t  wr_next;

  logic        step_down;
  logic [7:0]  step_res;
  logic        step_zero;
  logic [7:0]  adj_val;
  logic        accept;
  logic        adj_hit;
  logic        step_hit;
  logic        jump_hit;
  logic        skip_hit;
  logic        flag_hit;

  assign rf_raddr_o = instr_i.addr;
  assign step_down  = (instr_i.op == ASJ_DEC) || (instr_i.op == ASJ_DECSZ);

  asj_step u_step (
    .down_i (step_down),
    .val_i  (rf_rdata_i),
    .res_o  (step_res),
    .zero_o (step_zero)
  );

  // Subtraction borrows show as nibbles above nine; correct downward.
  always_comb begin
    adj_val = work_reg;
    if (adj_val[3:0] > `ASJ_NIB_LIMIT) begin
      adj_val = adj_val - `ASJ_NIB_ADJ;
    end
    if (work_reg > `ASJ_HI_LIMIT) begin
      adj_val = adj_val - `ASJ_HI_ADJ;
    end
  end

  // A new instruction is refused during the flush slot.
  assign accept = instr_valid_i && (state_reg == ASJ_EXEC);

  always_comb begin
    adj_hit  = 1'b0;
    step_hit = 1'b0;
    jump_hit = 1'b0;
    if (accept) begin
      case (instr_i.op)
        ASJ_ADJ: begin
          adj_hit = 1'b1;
        end
        ASJ_DEC, ASJ_INC, ASJ_DECSZ: begin
          step_hit = 1'b1;
        end
        ASJ_JMP: begin
          jump_hit = 1'b1;
        end
        default: begin
          adj_hit = 1'b0;
        end
      endcase
    end
  end

  // The skipping decrement never touches the flag; only the plain steps do.
  assign flag_hit = step_hit && (instr_i.op != ASJ_DECSZ);
  assign skip_hit = step_hit && (instr_i.op == ASJ_DECSZ) && step_zero;

  // The flush slot is the no-operation that stands in for the dropped fetch.
  always_comb begin
    case (state_reg)
      ASJ_EXEC: begin
        if (skip_hit || jump_hit) begin
          state_next = ASJ_FLUSH;
        end else begin
          state_next = ASJ_EXEC;
        end
      end
      ASJ_FLUSH: begin
        state_next = ASJ_EXEC;
      end
      default: begin
        state_next = ASJ_EXEC;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ASJ_EXEC;
    end else begin
      state_reg <= state_next;
    end
  end

  // In the execute state outside an update the flag follows the core, so untouched means unchanged.
  always_comb begin
    work_next = work_reg;
    zero_next = zero_reg;
    if (state_reg == ASJ_EXEC) begin
      zero_next = zero_i;
    end
    if (adj_hit) begin
      work_next = adj_val;
    end
    if (step_hit && !instr_i.dest) begin
      work_next = step_res;
    end
    if (flag_hit) begin
      zero_next = step_zero;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      work_reg <= `ASJ_W_RESET;
      zero_reg <= 1'b0;
    end else begin
      work_reg <= work_next;
      zero_reg <= zero_next;
    end
  end

  always_comb begin
    pc_next      = pc_reg;
    pc_load_next = 1'b0;
    if (jump_hit) begin
      pc_next      = instr_i.target;
      pc_load_next = 1'b1;
    end else if (!accept && (state_reg == ASJ_EXEC)) begin
      pc_next = pc_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg      <= `ASJ_PC_RESET;
      pc_load_reg <= 1'b0;
    end else begin
      pc_reg      <= pc_next;
      pc_load_reg <= pc_load_next;
    end
  end

  always_comb begin
    discard_next = skip_hit || jump_hit;
    wr_next      = '0;
    if (step_hit && instr_i.dest) begin
      wr_next.we   = 1'b1;
      wr_next.addr = instr_i.addr;
      wr_next.data = step_res;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      discard_reg <= 1'b0;
      wr_reg      <= '0;
    end else begin
      discard_reg <= discard_next;
      wr_reg      <= wr_next;
    end
  end

  assign work_o    = work_reg;
  assign zero_o    = zero_reg;
  assign pc_o      = pc_reg;
  assign pc_load_o = pc_load_reg;
  assign discard_o = discard_reg;
  assign rf_wr_o   = wr_reg;
  assign busy_o    = (state_reg == ASJ_FLUSH);
endmodule // asj_exec

// *** logic/asj_defs.svh ***
// Constants for the arithmetic, skip and jump execution block.
`ifndef ASJ_DEFS_SVH
`define ASJ_DEFS_SVH
`define ASJ_DATA_W      8
`define ASJ_ADDR_W      6
`define ASJ_PC_W        10
`define ASJ_ADDR_MAX    6'h3f
`define ASJ_PC_RESET    10'h000
`define ASJ_W_RESET     8'h00
`define ASJ_ONE         8'h01
`define ASJ_ZERO        8'h00
`define ASJ_NIB_LIMIT   4'h9
`define ASJ_NIB_ADJ     8'h06
`define ASJ_HI_ADJ      8'h60
`define ASJ_HI_LIMIT    8'h99
`define ASJ_OP_NONE     3'h0
`define ASJ_OP_ADJ      3'h1
`define ASJ_OP_DEC      3'h2
`define ASJ_OP_DECSZ    3'h3
`define ASJ_OP_JMP      3'h4
`define ASJ_OP_INC      3'h5
`endif

// *** logic/asj_pkg.sv ***
// Types for the arithmetic, skip and jump execution block.
package asj_pkg;
  typedef enum logic [2:0] {
    ASJ_NONE  = 3'h0,
    ASJ_ADJ   = 3'h1,
    ASJ_DEC   = 3'h2,
    ASJ_DECSZ = 3'h3,
    ASJ_JMP   = 3'h4,
    ASJ_INC   = 3'h5
  } asj_op_t;

  typedef struct packed {
    asj_op_t     op;
    logic        dest;
    logic [5:0]  addr;
    logic [9:0]  target;
  } asj_instr_t;

  typedef struct packed {
    logic        we;
    logic [5:0]  addr;
    logic [7:0]  data;
  } asj_rf_wr_t;

  // Execute follows the usual path with one Gray step into the flush slot.
  typedef enum logic [1:0] {
    ASJ_EXEC  = 2'b00,
    ASJ_FLUSH = 2'b01
  } asj_state_t;
endpackage

// *** logic/asj_step.sv ***
// Increment or decrement by one with wrap and zero detect.
`timescale 1ns/1ns
`include "asj_defs.svh"
module asj_step
  import asj_pkg::*;
(
  // Operand and direction
  input  wire logic       down_i,
  input  wire logic [7:0] val_i,
  // Result
  output logic [7:0]      res_o,
  output logic            zero_o
);
  always_comb begin
    if (down_i) begin
      res_o = val_i - `ASJ_ONE;
    end else begin
      res_o = val_i + `ASJ_ONE;
    end
    zero_o = (res_o == `ASJ_ZERO);
  end
endmodule // asj_step

// *** testbench/asj_exec_assertions.sv ***
// Property checker for the execution block.
`timescale 1ns/1ns
module asj_exec_chk
  import asj_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       instr_valid_i,
  input asj_instr_t      instr_i,
  input wire logic [7:0] rf_rdata_i,
  input asj_rf_wr_t      rf_wr_o,
  input wire logic       zero_i,
  input wire logic       zero_o,
  input wire logic [7:0] work_o,
  input wire logic [9:0] pc_o,
  input wire logic       pc_load_o,
  input wire logic       discard_o,
  input wire logic       busy_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic    tk;
  logic    one;
  asj_op_t op;
  assign tk = instr_valid_i && !busy_o;
  assign op = instr_i.op;
  assign one = rf_rdata_i == 8'h01;
  a_jump_load: assert property (
    tk && op == ASJ_JMP |=> pc_load_o && pc_o == $past(instr_i.target)) else $error("jump");
  a_jump_slot: assert property (
    tk && op == ASJ_JMP |=> discard_o && busy_o ##1 !busy_o) else $error("jump slot");
  a_skip_taken: assert property (
    tk && op == ASJ_DECSZ && one |=> discard_o && busy_o ##1 !busy_o) else $error("skip");
  a_no_slot: assert property (
    tk && (op inside {ASJ_ADJ, ASJ_DEC, ASJ_INC} || op == ASJ_DECSZ && !one)
    |=> !busy_o && !discard_o) else $error("no slot");
  a_flag_keep: assert property (
    tk && op inside {ASJ_ADJ, ASJ_DECSZ, ASJ_JMP} |=> zero_o == $past(zero_i))
    else $error("flag kept");
  a_dec_zero: assert property (
    tk && op == ASJ_DEC |=> zero_o == $past(one)) else $error("dec zero");
  a_inc_zero: assert property (
    tk && op == ASJ_INC |=> zero_o == ($past(rf_rdata_i) == 8'hff)) else $error("inc zero");
  a_dest_sel: assert property (
    tk && op inside {ASJ_DEC, ASJ_DECSZ, ASJ_INC} |=> rf_wr_o.we == $past(instr_i.dest))
    else $error("dest");
  a_wr_value: assert property (
    tk && instr_i.dest && op inside {ASJ_DEC, ASJ_DECSZ}
    |=> rf_wr_o.addr == $past(instr_i.addr) && rf_wr_o.data == $past(rf_rdata_i) - 8'h01)
    else $error("write value");
  a_work_step: assert property (
    tk && !instr_i.dest && op == ASJ_INC |=> work_o == $past(rf_rdata_i) + 8'h01)
    else $error("work step");
  a_slot_quiet: assert property (
    busy_o |=> !rf_wr_o.we && !pc_load_o && !discard_o) else $error("slot quiet");
endmodule // asj_exec_chk

bind asj_exec asj_exec_chk chk (.sys_clk_i, .rst_n_i, .instr_valid_i, .instr_i, .rf_rdata_i,
  .rf_wr_o, .zero_i, .zero_o, .work_o, .pc_o, .pc_load_o, .discard_o, .busy_o);

// *** testbench/tb_top.sv ***
// Self-checking bench for the execution block.
`timescale 1ns/1ns
module tb_top import asj_pkg::*;;
  typedef struct packed {
    asj_op_t op; logic d; logic [7:0] rd; logic zi; logic [7:0] res; logic z;
  } asj_row_t;
  logic       sys_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       instr_valid_i = 1'b0;
  asj_instr_t instr_i = '0;
  logic [7:0] rf_rdata_i = 8'h00;
  logic [9:0] pc_i = 10'h155;
  logic       zero_i = 1'b0;
  logic       zi = 1'b0;
  logic [7:0] work_o;
  logic       zero_o, pc_load_o, discard_o, busy_o;
  logic [9:0] pc_o;
  logic [5:0] rf_raddr_o;
  asj_rf_wr_t rf_wr_o;
  int         n_fail = 0;
  int         check_count = 0;
  // Rows run in order, so the adjust rows work on what the increment before them left.
  asj_row_t   rows [10] = '{
    '{ASJ_INC, 1'b0, 8'hff, 1'b0, 8'h00, 1'b1},
    '{ASJ_INC, 1'b1, 8'h7f, 1'b1, 8'h80, 1'b0},
    '{ASJ_DEC, 1'b0, 8'h00, 1'b0, 8'hff, 1'b0},
    '{ASJ_DEC, 1'b1, 8'h01, 1'b0, 8'h00, 1'b1},
    '{ASJ_DECSZ, 1'b0, 8'h05, 1'b1, 8'h04, 1'b1},
    '{ASJ_INC, 1'b0, 8'h0b, 1'b0, 8'h0c, 1'b0},
    '{ASJ_ADJ, 1'b0, 8'h00, 1'b1, 8'h06, 1'b1},
    '{ASJ_INC, 1'b0, 8'ha4, 1'b1, 8'ha5, 1'b0},
    '{ASJ_ADJ, 1'b0, 8'h00, 1'b0, 8'h45, 1'b0},
    '{ASJ_NONE, 1'b0, 8'h00, 1'b1, 8'h45, 1'b1}
  };
  always #5 sys_clk_i = ~sys_clk_i;
  asj_exec dut (.sys_clk_i, .rst_n_i, .instr_valid_i, .instr_i, .rf_rdata_i, .rf_raddr_o,
    .rf_wr_o, .pc_i, .zero_i, .work_o, .zero_o, .pc_o, .pc_load_o, .discard_o, .busy_o);
  task automatic chk(string n, logic [9:0] e, logic [9:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic go(asj_op_t op, logic d, logic [7:0] rd, logic [9:0] t, logic k);
    @(posedge sys_clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= '{op, d, 6'h2a, t};
    rf_rdata_i <= rd;
    zero_i <= zi;
    @(posedge sys_clk_i);
    instr_valid_i <= k;
    #1;
  endtask
  task automatic final_report;
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    foreach (rows[i]) begin
      zi = rows[i].zi;
      go(rows[i].op, rows[i].d, rows[i].rd, 10'h000, 1'b0);
      chk("res", rows[i].res, rows[i].d ? rf_wr_o.data : work_o);
      chk("zero", rows[i].z, zero_o);
    end
    go(ASJ_JMP, 1'b0, 8'h00, 10'h3ff, 1'b0);
    chk("pc", 10'h3ff, pc_o);
    chk("jslot", 10'h007, {pc_load_o, discard_o, busy_o});
    // The skip stays presented so that the slot edge must refuse it.
    go(ASJ_DECSZ, 1'b1, 8'h01, 10'h000, 1'b1);
    chk("skip", 10'h007, {rf_wr_o.we, discard_o, busy_o});
    chk("wdata", 10'h000, rf_wr_o.data);
    chk("waddr", 10'h02a, rf_wr_o.addr);
    chk("raddr", 10'h02a, rf_raddr_o);
    go(ASJ_INC, 1'b1, 8'h41, 10'h000, 1'b0);
    chk("after", 10'h142, {rf_wr_o.we, rf_wr_o.data});
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk("rst", 10'h000, {work_o, zero_o, busy_o});
    chk("rstpc", 10'h000, pc_o);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    go(ASJ_INC, 1'b0, 8'h10, 10'h000, 1'b0);
    chk("rerun", 10'h011, work_o);
    final_report;
  end
  initial begin
    #5000;
    n_fail++;
    final_report;
  end
endmodule // tb_top
